//--- hw/irmf_flags.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module irmf_flags #(
	parameter int NSRC = irmf_pkg::NUM_SRC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register access
	input wire irmf_pkg::irmf_bus_t bus,
	output logic [15:0] rdata,
	// sources and cpu
	input wire logic [NSRC-1:0] srcReq,
	input wire logic wdtIntervalMode,
	input wire logic ackValid,
	input wire logic [4:0] ackIdx,
	// pending towards cpu
	output logic intPending,
	output logic [4:0] intIdx
);
	irmf_pkg::irmf_state_t st_ff, nxt_st;
	logic [31:0] wrMaskReq, wrMaskMsk, wrVal, setV, clrV;
	logic [15:0] baseOff;
	logic hitReq, hitMsk, srvAny;
	logic [4:0] srvIdx;
	logic [31:0] usedBits;

	// group 1 high byte sits on top; request slots without a source stay zero
	assign usedBits = {irmf_pkg::G1H_USED, 8'hff, 16'hffff} &
		32'((33'h1 << NSRC) - 33'h1);

	// address decode; masks sit just above the request bytes
	always_comb begin
		hitReq = 1'b0;
		hitMsk = 1'b0;
		baseOff = '0;
		if (bus.addr >= irmf_pkg::ADDR_REQ_G0_LOW &&
			bus.addr <= irmf_pkg::ADDR_REQ_G1_HIGH) begin
			hitReq = 1'b1;
			baseOff = bus.addr - irmf_pkg::ADDR_REQ_G0_LOW;
		end else if (bus.addr >= irmf_pkg::ADDR_MASK_G0_LOW &&
			bus.addr <= irmf_pkg::ADDR_MASK_G1_HIGH) begin
			hitMsk = 1'b1;
			baseOff = bus.addr - irmf_pkg::ADDR_MASK_G0_LOW;
		end
	end

	// byte-lane write mask and aligned data
	logic [31:0] laneMask;
	always_comb begin
		laneMask = '0;
		wrVal = '0;
		case (bus.size)
			irmf_pkg::IRMF_SIZE_BIT: begin
				laneMask = 32'h1 << {baseOff[1:0], bus.bitSel};
				wrVal = {4{bus.wdata[7:0]}};
			end
			irmf_pkg::IRMF_SIZE_BYTE: begin
				laneMask = 32'hff << {baseOff[1:0], 3'h0};
				wrVal = {4{bus.wdata[7:0]}};
			end
			irmf_pkg::IRMF_SIZE_WORD: begin
				if (baseOff[1:0] == 2'h0) begin
					laneMask = 32'h0000ffff;
					wrVal = {2{bus.wdata}};
				end
			end
			default: begin
				laneMask = '0;
			end
		endcase
		if (bus.size == irmf_pkg::IRMF_SIZE_BIT)
			wrVal = {32{bus.wdata[0]}};
	end

	always_comb begin
		wrMaskReq = (bus.wrEn && hitReq) ? laneMask & usedBits : '0;
		wrMaskMsk = (bus.wrEn && hitMsk) ? laneMask : '0;
		// watchdog flag locked unless interval mode
		if (!wdtIntervalMode)
			wrMaskReq[irmf_pkg::WDT_BIT] = 1'b0;
	end

	// fixed order arbitration over unmasked pending
	irmf_prio_enc #(.N(NSRC), .W(5)) u_prio (
		.cand(st_ff.req[NSRC-1:0] & ~st_ff.mask[NSRC-1:0]),
		.any(srvAny),
		.idx(srvIdx)
	);

	always_comb begin
		nxt_st = st_ff;
		setV = '0;
		clrV = '0;
		setV[NSRC-1:0] = srcReq;
		// ack honoured for any unmasked source below NSRC, pending or not
		if (ackValid && ackIdx < 5'(NSRC) && !st_ff.mask[ackIdx])
			clrV[ackIdx] = 1'b1;
		nxt_st.req = (st_ff.req & ~wrMaskReq) | (wrVal & wrMaskReq);
		nxt_st.req = (nxt_st.req & ~clrV) | setV; // set wins over clear
		nxt_st.req = nxt_st.req & usedBits;
		nxt_st.mask = (st_ff.mask & ~wrMaskMsk) | (wrVal & wrMaskMsk);
		// read data holds until the next read strobe
		if (bus.rdEn) begin
			nxt_st.rdata = '0;
			if (hitReq) begin
				if (bus.size == irmf_pkg::IRMF_SIZE_WORD)
					nxt_st.rdata = st_ff.req[15:0];
				else
					nxt_st.rdata = {8'h00,
						8'(st_ff.req >> {baseOff[1:0], 3'h0})};
			end else if (hitMsk) begin
				if (bus.size == irmf_pkg::IRMF_SIZE_WORD)
					nxt_st.rdata = st_ff.mask[15:0];
				else
					nxt_st.rdata = {8'h00,
						8'(st_ff.mask >> {baseOff[1:0], 3'h0})};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff.req <= {4{irmf_pkg::REQ_RESET}};
			st_ff.mask <= {4{irmf_pkg::MASK_RESET}};
			st_ff.rdata <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign intPending = srvAny;
	assign intIdx = srvIdx;

	//////////////////////////////////////////////////////////////////////////
	a_req_sets: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		srcReq[3] |=> st_ff.req[3]) else $error("request not set");
	a_ack_clears: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		ackValid && ackIdx == 5'h5 && !st_ff.mask[5] && !srcReq[5] &&
		!(bus.wrEn && hitReq) |=> !st_ff.req[5])
		else $error("ack did not clear");
	a_masked_no_pend: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		intPending |-> !st_ff.mask[intIdx] && st_ff.req[intIdx])
		else $error("masked source pending");
	a_prio_lowest: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		intPending && intIdx != 5'h0 |-> !(st_ff.req[0] && !st_ff.mask[0]))
		else $error("priority order broken");
	a_prio_order: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		intPending |-> (st_ff.req & ~st_ff.mask & usedBits &
		((32'h1 << intIdx) - 32'h1)) == 32'h0)
		else $error("higher source passed over");
	a_wdt_locked: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!wdtIntervalMode && !srcReq[0] && !(ackValid && ackIdx == 5'h0)
		|=> st_ff.req[0] == $past(st_ff.req[0]))
		else $error("watchdog flag written");
	a_g1h_zero: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		st_ff.req[31:27] == 5'h00) else $error("reserved bits set");
	a_reset_vals: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(arst_n) |-> st_ff.req == '0 && st_ff.mask == '1)
		else $error("reset values wrong");
	a_req_bit_wr: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		bus.wrEn && bus.addr == irmf_pkg::ADDR_REQ_G1_LOW &&
		bus.size == irmf_pkg::IRMF_SIZE_BIT &&
		srcReq[23:16] == 8'h00 && !ackValid
		|=> st_ff.req[16 + $past(bus.bitSel)] == $past(bus.wdata[0]) &&
		((st_ff.req[23:16] ^ $past(st_ff.req[23:16])) &
		~(8'h01 << $past(bus.bitSel))) == 8'h00)
		else $error("bit write touched other bits");
	a_mask_byte_wr: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		bus.wrEn && bus.addr == irmf_pkg::ADDR_MASK_G1_LOW &&
		bus.size == irmf_pkg::IRMF_SIZE_BYTE
		|=> st_ff.mask[23:16] == $past(bus.wdata[7:0]))
		else $error("mask byte write lost");
	a_read_req: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		bus.rdEn && bus.addr == irmf_pkg::ADDR_REQ_G0_HIGH &&
		bus.size == irmf_pkg::IRMF_SIZE_BYTE
		|=> rdata == {8'h00, $past(st_ff.req[15:8])})
		else $error("read data wrong");
	a_word_rd: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		bus.rdEn && bus.addr == irmf_pkg::ADDR_REQ_G0_LOW &&
		bus.size == irmf_pkg::IRMF_SIZE_WORD
		|=> rdata == $past(st_ff.req[15:0]))
		else $error("word read wrong");
	a_mask_word_rd: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		bus.rdEn && bus.addr == irmf_pkg::ADDR_MASK_G0_LOW &&
		bus.size == irmf_pkg::IRMF_SIZE_WORD
		|=> rdata == $past(st_ff.mask[15:0]))
		else $error("mask word read wrong");
	a_rd_hold: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!bus.rdEn |=> rdata == $past(rdata))
		else $error("read data moved");
	c_ack: cover property (@(posedge ref_clk) ackValid && intPending);
	c_masked_set: cover property (@(posedge ref_clk)
		srcReq[5] && st_ff.mask[5]);
	c_word_wr: cover property (@(posedge ref_clk)
		bus.wrEn && bus.size == irmf_pkg::IRMF_SIZE_WORD);
	c_wdt_lock: cover property (@(posedge ref_clk)
		bus.wrEn && hitReq && !wdtIntervalMode);
	c_two_pending: cover property (@(posedge ref_clk)
		intPending && $countones(st_ff.req & ~st_ff.mask) > 1);
endmodule

//--- hw/irmf_pkg.sv
package irmf_pkg;
	localparam int NUM_SRC = 26;
	localparam logic [15:0] ADDR_REQ_G0_LOW = 16'hffe0;
	localparam logic [15:0] ADDR_REQ_G0_HIGH = 16'hffe1;
	localparam logic [15:0] ADDR_REQ_G1_LOW = 16'hffe2;
	localparam logic [15:0] ADDR_REQ_G1_HIGH = 16'hffe3;
	localparam logic [15:0] ADDR_MASK_G0_LOW = 16'hffe4;
	localparam logic [15:0] ADDR_MASK_G0_HIGH = 16'hffe5;
	localparam logic [15:0] ADDR_MASK_G1_LOW = 16'hffe6;
	localparam logic [15:0] ADDR_MASK_G1_HIGH = 16'hffe7;
	localparam logic [7:0] REQ_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam logic [7:0] G1H_USED = 8'h07;
	localparam int WDT_BIT = 0;

	typedef enum logic [1:0] {
		IRMF_SIZE_BIT = 2'h1,
		IRMF_SIZE_BYTE = 2'h2,
		IRMF_SIZE_WORD = 2'h3
	} irmf_size_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		irmf_size_t size;
		logic [2:0] bitSel;
		logic [15:0] addr;
		logic [15:0] wdata;
	} irmf_bus_t;

	typedef struct packed {
		logic [31:0] req;
		logic [31:0] mask;
		logic [15:0] rdata;
	} irmf_state_t;
endpackage

//--- hw/irmf_prio_enc.sv
`timescale 1ns/1ns
// fixed-order pick: lowest index wins
module irmf_prio_enc #(
	parameter int N = 26,
	parameter int W = 5
) (
	// candidates
	input wire logic [N-1:0] cand,
	// result
	output logic any,
	output logic [W-1:0] idx
);
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (cand[i]) begin
				any = 1'b1;
				idx = W'(i);
			end
		end
	end
endmodule

//--- tb/irmf_cpu_model.sv
`timescale 1ns/1ns
// sources give one-cycle pulses; cpu acks only the offered winner
module irmf_cpu_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// bench control
	input wire logic [25:0] raise,
	input wire logic ackOn,
	// flags block side
	input wire logic intPending,
	input wire logic [4:0] intIdx,
	output logic [25:0] srcReq,
	output logic ackValid,
	output logic [4:0] ackIdx
);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			srcReq <= '0;
			ackValid <= 1'b0;
			ackIdx <= 5'h1f;
		end else begin
			srcReq <= raise;
			ackValid <= ackOn & intPending;
			// idle index toggles so a stale value is never trusted
			ackIdx <= intPending ? intIdx : ~ackIdx;
		end
	end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	localparam irmf_pkg::irmf_size_t BI = irmf_pkg::IRMF_SIZE_BIT;
	localparam irmf_pkg::irmf_size_t BY = irmf_pkg::IRMF_SIZE_BYTE;
	localparam irmf_pkg::irmf_size_t WO = irmf_pkg::IRMF_SIZE_WORD;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	irmf_pkg::irmf_bus_t bus = '0;
	logic [15:0] rdata;
	logic [25:0] srcReq;
	logic [25:0] raise = '0;
	logic wdtMode = 1'b0;
	logic ackOn = 1'b0;
	logic ackValid, intPending;
	logic [4:0] ackIdx, intIdx;
	int err_total = 0;
	int check_count = 0;
	always #4 ref_clk = ~ref_clk;
	irmf_flags dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
		.rdata(rdata), .srcReq(srcReq), .wdtIntervalMode(wdtMode),
		.ackValid(ackValid), .ackIdx(ackIdx), .intPending(intPending),
		.intIdx(intIdx));
	irmf_cpu_model cpu_u (.ref_clk(ref_clk), .arst_n(arst_n),
		.raise(raise), .ackOn(ackOn), .intPending(intPending),
		.intIdx(intIdx), .srcReq(srcReq), .ackValid(ackValid),
		.ackIdx(ackIdx));
	//////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one bus assignment per step, so back-to-back calls are safe
	task automatic acc(input logic w, input logic r,
		input irmf_pkg::irmf_size_t sz, input logic [2:0] b,
		input logic [15:0] a, input logic [15:0] d);
		bus = '{w, r, sz, b, a, d};
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input irmf_pkg::irmf_size_t sz, input logic [2:0] b,
		input logic [15:0] a, input logic [15:0] d);
		acc(1'b1, 1'b0, sz, b, a, d);
	endtask
	task automatic rd(input irmf_pkg::irmf_size_t sz, input logic [15:0] a,
		input logic [15:0] exp);
		acc(1'b0, 1'b1, sz, 3'h0, a, 16'h0000);
		check(rdata, exp);
	endtask
	task automatic tick;
		acc(1'b0, 1'b0, BY, 3'h0, 16'h0000, 16'h0000);
	endtask
	task automatic stop_test;
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		err_total++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(BY, 16'hffe0 + 16'(i), i < 4 ? 16'h0000 : 16'h00ff);
		end
		wr(BY, 3'h0, 16'hffe2, 16'h00a5);
		wr(BI, 3'h1, 16'hffe2, 16'h0001);
		rd(BY, 16'hffe2, 16'h00a7);
		wr(BI, 3'h7, 16'hffe2, 16'h0000);
		rd(BY, 16'hffe2, 16'h0027);
		// bit 26 carries no source, so it reads back zero
		wr(BY, 3'h0, 16'hffe3, 16'h0007);
		rd(BY, 16'hffe3, 16'h0003);
		wdtMode = 1'b1;
		wr(WO, 3'h0, 16'hffe0, 16'h1235);
		rd(WO, 16'hffe0, 16'h1235);
		wdtMode = 1'b0;
		wr(BY, 3'h0, 16'hffe0, 16'h0000);
		rd(BY, 16'hffe0, 16'h0001);
		rd(BY, 16'hffe1, 16'h0012);
		wdtMode = 1'b1;
		wr(WO, 3'h0, 16'hffe0, 16'h0000);
		wr(BY, 3'h0, 16'hffe2, 16'h0000);
		wr(BY, 3'h0, 16'hffe3, 16'h0000);
		// masked sources still latch their request
		raise = 26'h0000220;
		tick;
		raise = '0;
		tick;
		check({15'h0000, intPending}, 16'h0000);
		rd(WO, 16'hffe0, 16'h0220);
		wr(WO, 3'h0, 16'hffe4, 16'hfddf);
		check({15'h0000, intPending}, 16'h0001);
		check({11'h000, intIdx}, 16'h0005);
		ackOn = 1'b1;
		tick;
		ackOn = 1'b0;
		tick;
		check({11'h000, intIdx}, 16'h0009);
		rd(WO, 16'hffe0, 16'h0200);
		wr(BY, 3'h0, 16'hffe6, 16'h005a);
		rd(BY, 16'hffe6, 16'h005a);
		wr(BI, 3'h2, 16'hffe5, 16'h0000);
		rd(BY, 16'hffe5, 16'h00f9);
		arst_n = 1'b0;
		tick;
		arst_n = 1'b1;
		rd(WO, 16'hffe4, 16'hffff);
		rd(WO, 16'hffe0, 16'h0000);
		stop_test;
	end
endmodule
